// >>> pkg/adc_cfg_pkg.sv
// Constants and state types for the configuration and alert status block
package adc_cfg_pkg;

	// ------------------------------------------------------------
	// Register map and frame layout
	// ------------------------------------------------------------
	localparam logic [4:0]  ADDR_RESULT = 5'h00;
	localparam logic [4:0]  ADDR_CFG    = 5'h02;
	localparam logic [4:0]  ADDR_FLAGS  = 5'h03;
	localparam int          FRM_BITS    = 16;
	localparam int          FRM_ADR_HI  = 15;
	localparam int          FRM_ADR_LO  = 11;
	localparam int          FRM_WR      = 10;
	localparam int          FRM_DAT_HI  = 9;
	localparam logic [4:0]  CNT_LAST    = 5'h0F;
	localparam logic [4:0]  CNT_CLR     = 5'h01;

	// ------------------------------------------------------------
	// Configuration fields
	// ------------------------------------------------------------
	localparam int          CFG_SOFTWARE_RESET_BIT    = 9;
	localparam int          CFG_STICKY  = 7;
	localparam int          CFG_DRIVE   = 6;
	localparam int          CFG_BUSY    = 5;
	localparam int          CFG_FNSEL   = 4;
	localparam int          CFG_POL     = 3;
	localparam int          CFG_GENERAL_OUTPUT_ONE_LEVEL    = 2;
	localparam int          CFG_PD_HI   = 1;
	localparam int          CFG_PD_LO   = 0;
	localparam logic [15:0] CFG_RST     = 16'h00C0;
	localparam logic [15:0] CFG_WMASK   = 16'h02FF;

	// ------------------------------------------------------------
	// Channels, limits and trim memory
	// ------------------------------------------------------------
	localparam int          CH_COUNT    = 8;
	localparam logic [15:0] FLAG_MASK   = 16'hFFFF;
	localparam logic [2:0]  PAD_LOW     = 3'h0;
	localparam logic [2:0]  PAD_HIGH    = 3'h7;
	localparam int          TRIM_N      = 8;
	localparam int          TRIM_W      = 8;

	// ------------------------------------------------------------
	// Read selection and state
	// ------------------------------------------------------------
	localparam logic [1:0]  SEL_RESULT  = 2'h0;
	localparam logic [1:0]  SEL_CFG     = 2'h1;
	localparam logic [1:0]  SEL_FLAGS   = 2'h2;

	typedef enum logic [0:0] {
		FRM_IDLE,
		FRM_SHIFT
	} frame_e;

	typedef struct packed {
		logic        sclk_m;
		logic        sclk_s;
		logic        sclk_p;
		logic        cs_m;
		logic        cs_s;
		logic        mosi_m;
		logic        mosi_s;
		frame_e      st;
		logic [4:0]  cnt;
		logic [15:0] rx;
		logic [15:0] sh;
		logic        miso;
		logic [15:0] cfg;
		logic [1:0]  pend;
		logic        clr_arm;
		logic        conv_seen;
		logic [15:0] flags;
		logic [7:0]  alert_ch;
		logic        mf_out;
		logic        mf_oe;
		logic        general_output_one_level;
		logic        bias_on;
		logic        ref_on;
		logic [11:0] thr;
	} cfg_state_s;

	typedef struct packed {
		logic [TRIM_N*TRIM_W-1:0] mem;
		logic [TRIM_W-1:0]        rd;
	} trim_state_s;

endpackage : adc_cfg_pkg

// >>> core/trim_store.sv
// Trim memory loaded from fuse contents, with registered read data
`timescale 1ns/1ps
module trim_store
	import adc_cfg_pkg::*;
(
	input  wire logic                     sys_clk_i,
	input  wire logic                     sys_rst_i,
	input  wire logic                     load_i,
	input  wire logic [TRIM_N*TRIM_W-1:0] fuse_i,
	input  wire logic [2:0]               addr_i,
	output logic      [TRIM_W-1:0]        data_o
);

	trim_state_s s_q;
	trim_state_s s_d;

	always_comb begin
		s_d = s_q;
		s_d.rd = s_q.mem[addr_i*TRIM_W +: TRIM_W];
		if (sys_rst_i || load_i) begin
			s_d.mem = fuse_i; // RQ3
		end
	end

	always_ff @(posedge sys_clk_i) begin
		s_q <= s_d;
	end

	assign data_o = s_q.rd;

	trim_reload_a: assert property (@(posedge sys_clk_i) // RQ3
		load_i |=> (s_q.mem == $past(fuse_i)))
		else $error("Trim memory not reloaded from fuses");

endmodule : trim_store

// >>> core/adc_config_and_alert_status.sv
// Configuration register, alert status flags and serial register access
`timescale 1ns/1ps
// Overview of operation
// (RQ1) Soft reset clears control logic, result path and flags, not other registers
// (RQ2) Soft reset bit clears itself one cycle after being set
// (RQ3) Soft reset reloads trim memory from fuses
// (RQ4) Sticky alert clears only on read or soft reset, else past hysteresis
// (RQ5) Drive type zero is open-drain, one is push-pull, resets to one
// (RQ6) Busy shown on pin when alert enabled; else busy reads as zero
// (RQ7) Polarity bit sets alert level when enabled, else general output level
// (RQ8) Function select zero gives general output, one gives alert or busy
// (RQ9) Second general output bit drives its pin, zero after reset
// (RQ10) Power-down field selects bias and reference on or off
// (RQ11) Status register is read-only with high and low flag per channel
// (RQ12) Set flag names channel and which limit was crossed
// (RQ13) Flags accumulate across channels until read
// (RQ14) Reading flags clears them on second serial clock of frame
// (RQ15) Conversion before read frame sends result and keeps flags
// (RQ16) Flags of unimplemented channels read zero
// (RQ17) Channel n high flag at bit 2n, low flag at 2n+1
// (RQ18) Nine-bit limits padded 000 for low and hysteresis, 111 for high
module adc_config_and_alert_status
	import adc_cfg_pkg::*;
(
	input  wire logic                     sys_clk_i,
	input  wire logic                     sys_rst_i,
	input  wire logic                     sclk_i,
	input  wire logic                     cs_n_i,
	input  wire logic                     mosi_i,
	output logic                          miso_o,
	input  wire logic [7:0]               viol_hi_i,
	input  wire logic [7:0]               viol_lo_i,
	input  wire logic [7:0]               in_band_i,
	input  wire logic                     busy_i,
	input  wire logic                     conv_done_i,
	input  wire logic [15:0]              result_i,
	input  wire logic [8:0]               limit_raw_i,
	input  wire logic                     limit_is_high_i,
	output logic      [11:0]              threshold_o,
	input  wire logic [TRIM_N*TRIM_W-1:0] fuse_i,
	input  wire logic [2:0]               trim_addr_i,
	output logic      [TRIM_W-1:0]        trim_data_o,
	output logic                          mf_out_o,
	output logic                          mf_oe_o,
	output logic                          general_output_one_level_o,
	output logic                          bias_on_o,
	output logic                          ref_on_o
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [11:0] expand_limit(input logic [8:0] raw,
		input logic high);
		expand_limit = {raw, high ? PAD_HIGH : PAD_LOW}; // RQ18
	endfunction : expand_limit

	function automatic logic [15:0] pack_flags(input logic [7:0] hi,
		input logic [7:0] lo);
		logic [15:0] f;
		f = '0;
		for (int n = 0; n < CH_COUNT; n++) begin
			f[2*n]   = hi[n]; // RQ17
			f[2*n+1] = lo[n]; // RQ17
		end
		pack_flags = f & FLAG_MASK; // RQ16
	endfunction : pack_flags

	cfg_state_s s_q;
	cfg_state_s s_d;
	logic       software_reset_bit_now;
	logic [15:0] cfg_rd;
	logic [15:0] viol;
	logic        alert_lvl;

	assign software_reset_bit_now = s_q.cfg[CFG_SOFTWARE_RESET_BIT];
	assign viol     = pack_flags(viol_hi_i, viol_lo_i); // RQ12

	// Busy bit reads as zero unless alert function is enabled
	always_comb begin
		cfg_rd = s_q.cfg;
		cfg_rd[CFG_BUSY] = s_q.cfg[CFG_BUSY] & s_q.cfg[CFG_FNSEL]; // RQ6
	end

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		logic rise;
		logic fall;
		logic [15:0] word;
		logic active;
		logic level;
		rise = 1'b0;
		fall = 1'b0;
		word = '0;
		active = 1'b0;
		level = 1'b0;
		s_d = s_q;
		s_d.sclk_m = sclk_i;
		s_d.sclk_s = s_q.sclk_m;
		s_d.sclk_p = s_q.sclk_s;
		s_d.cs_m   = cs_n_i;
		s_d.cs_s   = s_q.cs_m;
		s_d.mosi_m = mosi_i;
		s_d.mosi_s = s_q.mosi_m;
		rise = s_q.sclk_s & ~s_q.sclk_p;
		fall = ~s_q.sclk_s & s_q.sclk_p;
		s_d.cfg[CFG_SOFTWARE_RESET_BIT] = 1'b0; // RQ2
		case (s_q.st)
			FRM_IDLE: begin
				if (!s_q.cs_s) begin
					s_d.st = FRM_SHIFT;
					s_d.cnt = '0;
					s_d.conv_seen = 1'b0;
					s_d.pend = SEL_RESULT;
					s_d.clr_arm = 1'b0;
					if (s_q.conv_seen || s_q.pend == SEL_RESULT) begin
						s_d.sh = result_i; // RQ15
					end else if (s_q.pend == SEL_FLAGS) begin
						s_d.sh = s_q.flags; // RQ11
						s_d.clr_arm = 1'b1;
					end else begin
						s_d.sh = cfg_rd;
					end
				end
			end
			FRM_SHIFT: begin
				if (s_q.cs_s) begin
					s_d.st = FRM_IDLE;
				end else if (rise) begin
					word = {s_q.rx[14:0], s_q.mosi_s};
					s_d.rx = word;
					s_d.cnt = s_q.cnt + 5'h01;
					if (s_q.cnt == CNT_CLR && s_q.clr_arm) begin
						s_d.flags = '0; // RQ14
						s_d.alert_ch = '0; // RQ4
						s_d.clr_arm = 1'b0;
					end
					if (s_q.cnt == CNT_LAST) begin
						if (word[FRM_WR]
							&& word[FRM_ADR_HI:FRM_ADR_LO] == ADDR_CFG) begin
							s_d.cfg = (s_q.cfg & ~CFG_WMASK)
								| ({6'h00, word[FRM_DAT_HI:0]} & CFG_WMASK);
						end else if (!word[FRM_WR]) begin
							if (word[FRM_ADR_HI:FRM_ADR_LO] == ADDR_CFG) begin
								s_d.pend = SEL_CFG;
							end else if (word[FRM_ADR_HI:FRM_ADR_LO]
								== ADDR_FLAGS) begin
								s_d.pend = SEL_FLAGS;
							end
						end
					end
				end else if (fall) begin
					s_d.sh = {s_q.sh[14:0], 1'b0};
				end
			end
			default: s_d.st = FRM_IDLE;
		endcase
		// Soft reset of control logic and status; config kept
		if (software_reset_bit_now) begin
			s_d.st = FRM_IDLE; // RQ1
			s_d.cnt = '0;
			s_d.sh = '0;
			s_d.pend = SEL_RESULT;
			s_d.clr_arm = 1'b0;
			s_d.conv_seen = 1'b0;
			s_d.flags = '0;
			s_d.alert_ch = '0;
		end
		// Hardware set wins over any clear in the same cycle
		if (conv_done_i) begin
			s_d.conv_seen = 1'b1; // RQ15
		end
		s_d.flags = s_d.flags | viol; // RQ13
		if (!s_q.cfg[CFG_STICKY]) begin
			s_d.alert_ch = s_d.alert_ch & ~in_band_i; // RQ4
		end
		s_d.alert_ch = s_d.alert_ch | viol_hi_i | viol_lo_i;
		s_d.miso = s_d.sh[15];
		// Multifunction pin
		active = s_q.cfg[CFG_BUSY] ? busy_i : (|s_q.alert_ch); // RQ6
		if (s_q.cfg[CFG_FNSEL]) begin
			level = s_q.cfg[CFG_POL] ? active : ~active; // RQ8 RQ7
		end else begin
			level = s_q.cfg[CFG_POL]; // RQ7
		end
		if (s_q.cfg[CFG_DRIVE]) begin
			s_d.mf_out = level; // RQ5
			s_d.mf_oe = 1'b1;
		end else begin
			s_d.mf_out = 1'b0; // RQ5
			s_d.mf_oe = ~level;
		end
		s_d.general_output_one_level = s_q.cfg[CFG_GENERAL_OUTPUT_ONE_LEVEL]; // RQ9
		s_d.bias_on = s_q.cfg[CFG_PD_HI]; // RQ10
		s_d.ref_on = s_q.cfg[CFG_PD_LO]; // RQ10
		s_d.thr = expand_limit(limit_raw_i, limit_is_high_i); // RQ18
		if (sys_rst_i) begin
			s_d = '0;
			s_d.cfg = CFG_RST;
			s_d.cs_m = 1'b1;
			s_d.cs_s = 1'b1;
			s_d.st = FRM_IDLE;
		end
	end

	always_ff @(posedge sys_clk_i) begin
		s_q <= s_d;
	end

	// ------------------------------------------------------------
	// Trim memory and outputs
	// ------------------------------------------------------------
	trim_store u_trim (
		.sys_clk_i (sys_clk_i),
		.sys_rst_i (sys_rst_i),
		.load_i    (software_reset_bit_now), // RQ3
		.fuse_i    (fuse_i),
		.addr_i    (trim_addr_i),
		.data_o    (trim_data_o)
	);

	assign miso_o      = s_q.miso;
	assign mf_out_o    = s_q.mf_out;
	assign mf_oe_o     = s_q.mf_oe;
	assign general_output_one_level_o      = s_q.general_output_one_level;
	assign bias_on_o   = s_q.bias_on;
	assign ref_on_o    = s_q.ref_on;
	assign threshold_o = s_q.thr;
	assign alert_lvl   = |s_q.alert_ch;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	sequence software_reset_bit_seen;
		software_reset_bit_now && !sys_rst_i;
	endsequence

	sequence od_held;
		!s_q.cfg[CFG_DRIVE] [*2];
	endsequence

	software_reset_bit_self_clear_a: assert property (@(posedge sys_clk_i) // RQ2
		disable iff (sys_rst_i) software_reset_bit_seen |=> !software_reset_bit_now)
		else $error("Soft reset bit did not self clear");

	software_reset_bit_flags_a: assert property (@(posedge sys_clk_i) // RQ1
		disable iff (sys_rst_i) software_reset_bit_seen ##0 (viol == 16'h0000)
		|=> (s_q.flags == 16'h0000 && s_q.st == FRM_IDLE))
		else $error("Soft reset left flags or frame state");

	open_drain_a: assert property (@(posedge sys_clk_i) // RQ5
		disable iff (sys_rst_i) od_held |-> !mf_out_o)
		else $error("Open-drain pin driven high");

	busy_read_a: assert property (@(posedge sys_clk_i) // RQ6
		disable iff (sys_rst_i)
		(s_q.st == FRM_IDLE && !s_q.cs_s && s_q.pend == SEL_CFG
		&& !s_q.conv_seen && !s_q.cfg[CFG_FNSEL]) |=> !s_q.sh[CFG_BUSY])
		else $error("Busy bit read back while alert disabled");

	gpo_level_a: assert property (@(posedge sys_clk_i) // RQ7
		disable iff (sys_rst_i)
		(!s_q.cfg[CFG_FNSEL] && s_q.cfg[CFG_DRIVE]) [*2]
		|-> mf_out_o == $past(s_q.cfg[CFG_POL]))
		else $error("General output level mismatch");

	flag_hold_a: assert property (@(posedge sys_clk_i) // RQ13
		disable iff (sys_rst_i)
		viol != 16'h0000 |=> (s_q.flags & $past(viol)) == $past(viol))
		else $error("Violation flag lost");

	read_clear_a: assert property (@(posedge sys_clk_i) // RQ14
		disable iff (sys_rst_i)
		(s_q.st == FRM_SHIFT && s_q.clr_arm && s_q.cnt == CNT_CLR
		&& !s_q.cs_s
		&& s_q.sclk_s && !s_q.sclk_p && !software_reset_bit_now && viol == 16'h0000)
		|=> s_q.flags == 16'h0000 ##1 !s_q.clr_arm)
		else $error("Flags not cleared on second serial clock");

	unimpl_zero_a: assert property (@(posedge sys_clk_i) // RQ16
		disable iff (sys_rst_i) (s_q.flags & ~FLAG_MASK) == 16'h0000)
		else $error("Unimplemented channel flag set");

	power_mode_a: assert property (@(posedge sys_clk_i) // RQ10
		disable iff (sys_rst_i) $stable(s_q.cfg) |->
		{bias_on_o, ref_on_o} == s_q.cfg[CFG_PD_HI:CFG_PD_LO])
		else $error("Power-down mode outputs wrong");

	sticky_hold_a: assert property (@(posedge sys_clk_i) // RQ4
		disable iff (sys_rst_i)
		(alert_lvl && s_q.cfg[CFG_STICKY] && !s_q.clr_arm && !software_reset_bit_now)
		|=> alert_lvl)
		else $error("Sticky alert cleared without read");

endmodule : adc_config_and_alert_status

// >>> verif/spi_host_model.sv
// Host controller model issuing mode-0 serial frames
`timescale 1ns/1ps
module spi_host_model #(
	parameter int HALF_NS = 24
) (
	output logic      sclk_o,
	output logic      cs_n_o,
	output logic      mosi_o,
	input  wire logic miso_i
);
	initial begin
		sclk_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end

	// Clock stands low outside frames, data inverted once released
	task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
		int i;
		cs_n_o = 1'b0;
		for (i = 15; i >= 0; i--) begin
			mosi_o = tx[i];
			#(HALF_NS);
			sclk_o = 1'b1;
			rx[i]  = miso_i;
			#(HALF_NS);
			sclk_o = 1'b0;
		end
		#(HALF_NS);
		cs_n_o = 1'b1;
		mosi_o = ~mosi_o;
		#(2 * HALF_NS);
	endtask : xfer
endmodule : spi_host_model

// >>> verif/adc_config_and_alert_status_tb_top.sv
// Self-checking bench of the configuration and alert status block
`timescale 1ns/1ps
module adc_config_and_alert_status_tb_top;
	import adc_cfg_pkg::*;
	logic        sys_clk_i, sys_rst_i, sclk, cs_n, mosi, miso;
	logic [7:0]  viol_hi_i, viol_lo_i, in_band_i;
	logic        busy_i, conv_done_i, limit_is_high_i;
	logic [15:0] result_i, v;
	logic [8:0]  limit_raw_i;
	logic [11:0] threshold_o;
	logic [63:0] fuse_i;
	logic [2:0]  trim_addr_i, a, b;
	logic [7:0]  trim_data_o;
	logic        mf_out_o, mf_oe_o, general_output_one_level_o, bias_on_o, ref_on_o;
	logic [31:0] seed;
	logic [9:0]  d;
	int          err_count, cmp_count, cyc, k;

	adc_config_and_alert_status DUT (.sys_clk_i(sys_clk_i),
		.sys_rst_i(sys_rst_i), .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi),
		.miso_o(miso), .viol_hi_i(viol_hi_i), .viol_lo_i(viol_lo_i),
		.in_band_i(in_band_i), .busy_i(busy_i), .conv_done_i(conv_done_i),
		.result_i(result_i), .limit_raw_i(limit_raw_i),
		.limit_is_high_i(limit_is_high_i), .threshold_o(threshold_o),
		.fuse_i(fuse_i), .trim_addr_i(trim_addr_i), .trim_data_o(trim_data_o),
		.mf_out_o(mf_out_o), .mf_oe_o(mf_oe_o), .general_output_one_level_o(general_output_one_level_o),
		.bias_on_o(bias_on_o), .ref_on_o(ref_on_o));
	spi_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
		.miso_i(miso));

	initial begin
		sys_clk_i = 1'b0;
		forever #2.5 sys_clk_i = ~sys_clk_i;
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", cmp_count, err_count);
		if (err_count == 0 && cmp_count > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : test_done

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			err_count++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		logic [31:0] r;
		r = s;
		repeat (32) r = {r[30:0], r[31]^r[21]^r[1]^r[0]};
		return r;
	endfunction : lfsr

	task automatic nx();
		seed = lfsr(seed);
	endtask : nx

	function automatic logic [15:0] exp_cfg(input logic [9:0] w);
		logic [15:0] e;
		e = {6'h00, w} & 16'h00FF;
		if (!e[CFG_FNSEL]) e[CFG_BUSY] = 1'b0;
		return e;
	endfunction : exp_cfg

	function automatic logic [1:0] exp_pin(input logic [15:0] c,
		input logic act);
		logic lvl;
		lvl = c[CFG_FNSEL] ? (act ~^ c[CFG_POL]) : c[CFG_POL];
		return c[CFG_DRIVE] ? {lvl, 1'b1} : {1'b0, ~lvl};
	endfunction : exp_pin

	task automatic wr(input logic [9:0] w);
		logic [15:0] r;
		host.xfer({ADDR_CFG, 1'b1, w}, r);
	endtask : wr

	task automatic rd(input logic [4:0] ad, output logic [15:0] r);
		logic [15:0] t;
		host.xfer({ad, 11'h000}, t);
		host.xfer({ADDR_RESULT, 11'h000}, r);
	endtask : rd

	task automatic pulse(input logic [7:0] hi, lo, band);
		@(negedge sys_clk_i);
		viol_hi_i = hi;
		viol_lo_i = lo;
		in_band_i = band;
		@(negedge sys_clk_i);
		{viol_hi_i, viol_lo_i, in_band_i} = '0;
	endtask : pulse

	task automatic pins(input logic [15:0] c, input logic act);
		repeat (4) @(negedge sys_clk_i);
		chk({14'h0000, mf_out_o, mf_oe_o}, {14'h0000, exp_pin(c, act)});
		chk({13'h0000, general_output_one_level_o, bias_on_o, ref_on_o}, {13'h0000, c[2:0]});
	endtask : pins

	always @(posedge sys_clk_i) begin
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			test_done();
		end
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		{viol_hi_i, viol_lo_i, in_band_i, busy_i, conv_done_i} = '0;
		{limit_raw_i, limit_is_high_i, trim_addr_i} = '0;
		result_i = 16'h0000;
		fuse_i = 64'h0123_4567_89AB_CDEF;
		seed = 32'h4ee2_f20f;
		sys_rst_i = 1'b1;
		repeat (4) @(negedge sys_clk_i);
		sys_rst_i = 1'b0;
		repeat (4) @(negedge sys_clk_i);
		rd(ADDR_CFG, v);
		chk(v, 16'h00C0);
		rd(ADDR_FLAGS, v);
		chk(v, 16'h0000);
		pins(16'h00C0, 1'b0);
		$display("test reset done");
		for (k = 0; k < 8; k++) begin
			nx();
			d = {1'b0, seed[8:0]};
			if (k < 4) d[1:0] = k[1:0];
			wr(d);
			rd(ADDR_CFG, v);
			chk(v, exp_cfg(d));
			pins(exp_cfg(d), 1'b0);
		end
		$display("test config done");
		nx();
		a = seed[2:0];
		b = a + 3'h3;
		wr(10'h0D8);
		pulse(8'h01 << a, 8'h00, 8'h00);
		pulse(8'h00, 8'h01 << b, 8'hFF);
		pins(16'h00D8, 1'b1);
		rd(ADDR_FLAGS, v);
		chk(v, (16'h0001 << (2*a)) | (16'h0002 << (2*b)));
		pins(16'h00D8, 1'b0);
		rd(ADDR_FLAGS, v);
		chk(v, 16'h0000);
		pulse(8'h80, 8'h00, 8'h00);
		host.xfer({ADDR_FLAGS, 11'h000}, v);
		@(negedge sys_clk_i);
		result_i = seed[31:16];
		conv_done_i = 1'b1;
		@(negedge sys_clk_i);
		conv_done_i = 1'b0;
		host.xfer({ADDR_RESULT, 11'h000}, v);
		chk(v, seed[31:16]);
		rd(ADDR_FLAGS, v);
		chk(v, 16'h4000);
		$display("test flags done");
		wr(10'h058);
		pulse(8'h00, 8'h04, 8'h00);
		pins(16'h0058, 1'b1);
		pulse(8'h00, 8'h00, 8'h04);
		pins(16'h0058, 1'b0);
		wr(10'h018);
		pulse(8'h02, 8'h00, 8'h00);
		pins(16'h0018, 1'b1);
		pulse(8'h00, 8'h00, 8'h02);
		pins(16'h0018, 1'b0);
		wr(10'h078);
		@(negedge sys_clk_i);
		busy_i = 1'b1;
		pins(16'h0078, 1'b1);
		busy_i = 1'b0;
		pins(16'h0078, 1'b0);
		$display("test pin done");
		pulse(8'h01, 8'h00, 8'h00);
		nx();
		fuse_i = {seed, ~seed};
		wr(10'h278);
		rd(ADDR_CFG, v);
		chk(v, 16'h0078);
		rd(ADDR_FLAGS, v);
		chk(v, 16'h0000);
		for (k = 0; k < 8; k++) begin
			trim_addr_i = k[2:0];
			repeat (3) @(negedge sys_clk_i);
			chk({8'h00, trim_data_o}, {8'h00, fuse_i[k*8 +: 8]});
		end
		$display("test soft reset done");
		for (k = 0; k < 8; k++) begin
			nx();
			limit_raw_i = seed[8:0];
			limit_is_high_i = seed[9];
			repeat (2) @(negedge sys_clk_i);
			chk({4'h0, threshold_o},
				{4'h0, seed[8:0], seed[9] ? 3'h7 : 3'h0});
		end
		$display("test threshold done");
		@(negedge sys_clk_i);
		sys_rst_i = 1'b1;
		repeat (2) @(negedge sys_clk_i);
		sys_rst_i = 1'b0;
		repeat (4) @(negedge sys_clk_i);
		rd(ADDR_CFG, v);
		chk(v, 16'h00C0);
		pins(16'h00C0, 1'b0);
		$display("test mid reset done");
		test_done();
	end
endmodule : adc_config_and_alert_status_tb_top
